// ==== dv/shsc_host.sv ====
// host bus master model driving scl and an open-drain sda
// assumes sda_bus is the resolved wire with a pull-up
`timescale 1ns/10ps
`default_nettype none
`include "shsc_defines.svh"
module shsc_host (
  input  wire logic sda_bus,
  output logic      scl,
  output logic      sda_drv
);
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // sda moves 40 ns after scl falls, never with it
  task automatic bit_io(input logic b, output logic r);
    #40 sda_drv = b;
    #160 scl = 1'b1;
    #160 r = sda_bus;
    scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] t, input logic m,
                      output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(t[i], r[i]);
    bit_io(m, a);
  endtask
  task automatic start_c();
    #160 sda_drv = 1'b0;
    #160 scl = 1'b0;
  endtask
  task automatic stop_c();
    #40 sda_drv = 1'b0;
    #160 scl = 1'b1;
    #160 sda_drv = 1'b1;
    #2000;
  endtask
  task automatic send(input logic [7:0] q[$]);
    logic [7:0] r;
    logic       a;
    start_c();
    foreach (q[i])
      xfer(q[i], 1'b1, r, a);
    stop_c();
  endtask
  task automatic fetch(output logic [23:0] d);
    logic [7:0] r;
    logic       a;
    start_c();
    xfer({`SHSC_I2C_ADDR, 1'b1}, 1'b1, r, a);
    for (int k = 0; k < 3; k++)
    begin
      xfer(8'hff, k == 2, r, a);
      d = {d[15:0], r};
    end
    stop_c();
  endtask
  // scl pulsed low nine times with sda left high
  task automatic if_reset();
    repeat (9)
    begin
      #160 scl = 1'b0;
      #160 scl = 1'b1;
    end
    #2000;
  endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// self-checking bench of the heater, status and crc block
// assumes shsc_host acts as bus master on the link pins
`timescale 1ns/10ps
`default_nettype none
`include "shsc_defines.svh"
module tb_top;
  logic        core_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        sys_rst_req = 1'b0;
  logic        supply_fail = 1'b0;
  logic        humidity_track_alert = 1'b0;
  logic        temp_track_alert = 1'b0;
  logic        scl, sda_drv, sda_out, sda_oe, heater_en, sda_bus;
  logic [15:0] status_word;
  logic [23:0] rd;
  int          n_fail = 0;
  int          samples_checked = 0;
  assign sda_bus = sda_drv & ~(sda_oe & ~sda_out);
  always #4 core_clk = ~core_clk;
  initial #3.3 forever #7.5 link_clk = ~link_clk;
  shsc_top #(.RST_CYCLES(2000)) DUT (.core_clk(core_clk),
    .reset_n(reset_n), .link_clk(link_clk), .scl_in(scl),
    .sda_in(sda_bus), .sda_out(sda_out), .sda_oe(sda_oe),
    .sys_rst_req(sys_rst_req), .supply_fail(supply_fail),
    .humidity_track_alert(humidity_track_alert),
    .temp_track_alert(temp_track_alert), .heater_en(heater_en),
    .status_word(status_word));
  shsc_host u_host (.sda_bus(sda_bus), .scl(scl), .sda_drv(sda_drv));
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic cmd(input logic [7:0] q[$]);
    q.push_front({`SHSC_I2C_ADDR, 1'b0});
    u_host.send(q);
    cyc(20);
  endtask
  task automatic rdchk(input logic [15:0] e);
    u_host.fetch(rd);
    chk(rd[23:8], e);
    chk({8'h00, rd[7:0]}, {8'h00, crc8(e)});
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #700000;
    n_fail++;
    give_verdict();
  end
  initial
  begin
    cyc(5);
    chk(status_word, 16'h8010);
    reset_n <= 1'b1;
    cyc(2100);
    chk({15'h0, heater_en}, 16'h0);
    rdchk(16'h8010);
    cmd('{8'h30, 8'h6d});
    chk({15'h0, heater_en}, 16'h1);
    rdchk(16'ha010);
    cmd('{8'h30, 8'h12});
    chk(status_word, 16'ha012);
    cmd('{8'h30, 8'h6d, 8'hbe, 8'hef, crc8(16'hbeef) ^ 8'h01});
    chk(status_word, 16'ha013);
    cmd('{8'h30, 8'h6d, 8'hbe, 8'hef, crc8(16'hbeef)});
    chk(status_word, 16'ha012);
    cmd('{8'h30, 8'h41});
    chk(status_word, 16'h2000);
    humidity_track_alert <= 1'b1;
    cyc(1);
    humidity_track_alert <= 1'b0;
    cyc(4);
    chk(status_word, 16'ha800);
    temp_track_alert <= 1'b1;
    cyc(1);
    temp_track_alert <= 1'b0;
    cyc(4);
    chk(status_word, 16'hac00);
    cmd('{8'h30, 8'h41});
    u_host.if_reset();
    chk(status_word, 16'h2000);
    cmd('{8'h30, 8'h66});
    chk({heater_en, status_word[14:0]}, 16'h0000);
    rdchk(16'h0000);
    sys_rst_req <= 1'b1;
    cyc(4);
    sys_rst_req <= 1'b0;
    cmd('{8'h30, 8'h6d});
    cyc(2100);
    chk({heater_en, status_word[14:0]}, 16'h0010);
    cmd('{8'h30, 8'h41});
    supply_fail <= 1'b1;
    cyc(4);
    supply_fail <= 1'b0;
    cyc(10);
    chk(status_word, 16'h8010);
    give_verdict();
  end
endmodule
`default_nettype wire

// ==== verilog/shsc_crc8.sv ====
// crc-8 of one 16-bit word, msb first
// assumes a caller that presents the word as a level
`timescale 1ns/10ps
`default_nettype none
`include "shsc_defines.svh"

module shsc_crc8 (
  input  wire logic [15:0] data,
  output logic      [7:0]  crc
);
  logic [7:0] acc;

  always_comb
  begin
    acc = `SHSC_CRC_INIT;
    for (int i = 15; i >= 0; i--)
    begin
      if (acc[7] ^ data[i])
        acc = {acc[6:0], 1'b0} ^ `SHSC_CRC_POLY;
      else
        acc = {acc[6:0], 1'b0};
    end
    crc = acc ^ `SHSC_CRC_XOROUT;
  end
endmodule

`default_nettype wire

// ==== verilog/shsc_defines.svh ====
// constants of the sensor heater, status and crc block
// assumes inclusion by bare name from each file that uses its macros
`ifndef SHSC_DEFINES_SVH
`define SHSC_DEFINES_SVH

// ----------------------------------------------------------------
// link addressing and commands
// ----------------------------------------------------------------
`define SHSC_I2C_ADDR      7'h2a
`define SHSC_CMD_HEAT_ON   16'h306d
`define SHSC_CMD_HEAT_OFF  16'h3066
`define SHSC_CMD_CLR_STAT  16'h3041
`define SHSC_NB_CMD        3'h2
`define SHSC_NB_WR         3'h5
`define SHSC_NB_MAX        3'h7
`define SHSC_FRAME_W       43
`define SHSC_PAD_BYTE      8'hff

// ----------------------------------------------------------------
// crc-8 properties
// ----------------------------------------------------------------
`define SHSC_CRC_POLY      8'h31
`define SHSC_CRC_INIT      8'hff
`define SHSC_CRC_XOROUT    8'h00

// ----------------------------------------------------------------
// status word layout and reset value
// ----------------------------------------------------------------
`define SHSC_ST_ALERT      15
`define SHSC_ST_HEATER     13
`define SHSC_ST_HUM        11
`define SHSC_ST_TEMP       10
`define SHSC_ST_RESET      4
`define SHSC_ST_CMD        1
`define SHSC_ST_WRCRC      0
`define SHSC_ST_RESET_VAL  16'h8010

// ----------------------------------------------------------------
// reset procedure timing
// ----------------------------------------------------------------
`define SHSC_CLK_MHZ       125
`define SHSC_RST_NS        200
`define SHSC_RST_CYC       ((`SHSC_RST_NS * `SHSC_CLK_MHZ + 999) / 1000)

`endif

// ==== verilog/shsc_pkg.sv ====
// state types of the sensor heater, status and crc block
// assumes nothing beyond a systemverilog compiler
package shsc_pkg;

  typedef enum logic [4:0]
  {
    lk_idle = 5'h01,
    lk_rxb  = 5'h02,
    lk_ack  = 5'h04,
    lk_txb  = 5'h08,
    lk_mack = 5'h10
  } shsc_link_e;

  typedef enum logic [1:0]
  {
    cs_busy = 2'h1,
    cs_run  = 2'h2
  } shsc_core_e;

endpackage

// ==== verilog/shsc_top.sv ====
// heater commands, status word and crc of the sensor serial port
// assumes scl/sda pins from the bus, link_clk oversampling them
`timescale 1ns/10ps
`default_nettype none
`include "shsc_defines.svh"

module shsc_top #(parameter int RST_CYCLES = `SHSC_RST_CYC) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        link_clk,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        sys_rst_req,
  input  wire logic        supply_fail,
  input  wire logic        humidity_track_alert,
  input  wire logic        temp_track_alert,
  output logic             heater_en,
  output logic      [15:0] status_word
);
  // ----------------------------------------------------------------
  // domain crossings
  // ----------------------------------------------------------------
  shsc_xfer_if #(.WIDTH(`SHSC_FRAME_W)) fr_if ();
  shsc_xfer_if #(.WIDTH(16))            st_if ();

  shsc_xfer #(.WIDTH(`SHSC_FRAME_W)) u_fr_xfer (
    .src_clk (link_clk),
    .dst_clk (core_clk),
    .reset_n (reset_n),
    .x       (fr_if.link)
  );

  shsc_xfer #(.WIDTH(16)) u_st_xfer (
    .src_clk (core_clk),
    .dst_clk (link_clk),
    .reset_n (reset_n),
    .x       (st_if.link)
  );

  // ----------------------------------------------------------------
  // link side: byte engine on link_clk
  // ----------------------------------------------------------------
  logic                     scl_s1_r, scl_s2_r, scl_d_r;
  logic                     sda_s1_r, sda_s2_r, sda_d_r;
  shsc_pkg::shsc_link_e     lst_r, lst_nxt;
  logic [3:0]               bit_r, bit_nxt;
  logic [7:0]               sh_r, sh_nxt;
  logic                     addr_r, addr_nxt;
  logic                     rd_r, rd_nxt;
  logic [2:0]               nb_r, nb_nxt;
  logic [7:0]               rx_r [5];
  logic [7:0]               rx_nxt [5];
  logic [1:0]               tix_r, tix_nxt;
  logic                     more_r, more_nxt;
  logic                     lvl_r, lvl_nxt;
  logic                     oe_r, oe_nxt;
  logic                     pend_r, pend_nxt;
  logic [`SHSC_FRAME_W-1:0] frm_r, frm_nxt;
  logic [15:0]              stl_r, stl_nxt;
  logic [15:0]              rdw_r, rdw_nxt;
  logic [7:0]               rd_crc;
  logic [7:0]               tx_byte;
  logic                     scl_rise, scl_fall, start_c, stop_c;

  assign scl_rise = scl_s2_r & ~scl_d_r;
  assign scl_fall = ~scl_s2_r & scl_d_r;
  assign start_c  = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  assign stop_c   = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

  // read crc covers only the two bytes just sent
  shsc_crc8 u_rd_crc (
    .data (rdw_r),
    .crc  (rd_crc)
  );

  always_comb
  begin
    case (tix_r)
      2'h0:    tx_byte = rdw_r[15:8];
      2'h1:    tx_byte = rdw_r[7:0];
      2'h2:    tx_byte = rd_crc;
      default: tx_byte = `SHSC_PAD_BYTE;
    endcase
  end

  always_comb
  begin
    lst_nxt  = lst_r;
    bit_nxt  = bit_r;
    sh_nxt   = sh_r;
    addr_nxt = addr_r;
    rd_nxt   = rd_r;
    nb_nxt   = nb_r;
    rx_nxt   = rx_r;
    tix_nxt  = tix_r;
    more_nxt = more_r;
    lvl_nxt  = lvl_r;
    oe_nxt   = oe_r;
    frm_nxt  = frm_r;
    rdw_nxt  = rdw_r;
    pend_nxt = pend_r & ~fr_if.src_ready;
    stl_nxt  = st_if.dst_valid ? st_if.dst_data : stl_r;
    if (start_c || stop_c)
    begin
      // start/stop hands a written frame to the core and restarts the engine; status lives elsewhere
      if (nb_r != 3'h0 && !rd_r && !pend_r)
      begin
        pend_nxt = 1'b1;
        frm_nxt  = {nb_r, rx_r[0], rx_r[1], rx_r[2], rx_r[3], rx_r[4]};
      end
      lst_nxt  = start_c ? shsc_pkg::lk_rxb : shsc_pkg::lk_idle;
      bit_nxt  = 4'h0;
      // every read starts again at the status msb
      tix_nxt  = 2'h0;
      addr_nxt = 1'b1;
      rd_nxt   = 1'b0;
      nb_nxt   = 3'h0;
      lvl_nxt  = 1'b1;
      oe_nxt   = 1'b0;
    end
    else
    begin
      case (lst_r)
        shsc_pkg::lk_idle: ;
        shsc_pkg::lk_rxb:
          if (scl_rise)
          begin
            sh_nxt  = {sh_r[6:0], sda_s2_r};
            bit_nxt = bit_r + 4'h1;
          end
          else if (scl_fall && bit_r == 4'h8)
          begin
            bit_nxt  = 4'h0;
            addr_nxt = 1'b0;
            lvl_nxt  = 1'b0;
            oe_nxt   = 1'b1;
            lst_nxt  = shsc_pkg::lk_ack;
            if (addr_r)
            begin
              rd_nxt  = sh_r[0];
              rdw_nxt = stl_r;
              if (sh_r[7:1] != `SHSC_I2C_ADDR)
              begin
                lvl_nxt = 1'b1;
                oe_nxt  = 1'b0;
                lst_nxt = shsc_pkg::lk_idle;
              end
            end
            else
            begin
              if (nb_r < `SHSC_NB_WR)
                rx_nxt[nb_r] = sh_r;
              if (nb_r != `SHSC_NB_MAX)
                nb_nxt = nb_r + 3'h1;
            end
          end
        shsc_pkg::lk_ack:
          if (scl_fall)
          begin
            if (rd_r)
            begin
              sh_nxt  = tx_byte;
              lvl_nxt = tx_byte[7];
              oe_nxt  = ~tx_byte[7];
              tix_nxt = 2'h1;
              lst_nxt = shsc_pkg::lk_txb;
            end
            else
            begin
              lvl_nxt = 1'b1;
              oe_nxt  = 1'b0;
              lst_nxt = shsc_pkg::lk_rxb;
            end
          end
        shsc_pkg::lk_txb:
          if (scl_fall)
          begin
            if (bit_r == 4'h7)
            begin
              bit_nxt = 4'h0;
              lvl_nxt = 1'b1;
              oe_nxt  = 1'b0;
              lst_nxt = shsc_pkg::lk_mack;
            end
            else
            begin
              sh_nxt  = {sh_r[6:0], 1'b0};
              lvl_nxt = sh_r[6];
              oe_nxt  = ~sh_r[6];
              bit_nxt = bit_r + 4'h1;
            end
          end
        shsc_pkg::lk_mack:
          if (scl_rise)
            more_nxt = ~sda_s2_r;
          else if (scl_fall)
          begin
            if (more_r)
            begin
              sh_nxt  = tx_byte;
              lvl_nxt = tx_byte[7];
              oe_nxt  = ~tx_byte[7];
              tix_nxt = (tix_r == 2'h3) ? tix_r : tix_r + 2'h1;
              lst_nxt = shsc_pkg::lk_txb;
            end
            else
              lst_nxt = shsc_pkg::lk_idle;
          end
        default: lst_nxt = shsc_pkg::lk_idle;
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {scl_s1_r, scl_s2_r, scl_d_r} <= 3'h7;
      {sda_s1_r, sda_s2_r, sda_d_r} <= 3'h7;
      lst_r  <= shsc_pkg::lk_idle;
      bit_r  <= 4'h0;
      sh_r   <= 8'h00;
      addr_r <= 1'b1;
      rd_r   <= 1'b0;
      nb_r   <= 3'h0;
      for (int i = 0; i < 5; i++)
        rx_r[i] <= 8'h00;
      tix_r  <= 2'h0;
      more_r <= 1'b0;
      lvl_r  <= 1'b1;
      oe_r   <= 1'b0;
      pend_r <= 1'b0;
      frm_r  <= '0;
      stl_r  <= `SHSC_ST_RESET_VAL;
      rdw_r  <= `SHSC_ST_RESET_VAL;
    end
    else
    begin
      {scl_s1_r, scl_s2_r, scl_d_r} <= {scl_in, scl_s1_r, scl_s2_r};
      {sda_s1_r, sda_s2_r, sda_d_r} <= {sda_in, sda_s1_r, sda_s2_r};
      lst_r  <= lst_nxt;
      bit_r  <= bit_nxt;
      sh_r   <= sh_nxt;
      addr_r <= addr_nxt;
      rd_r   <= rd_nxt;
      nb_r   <= nb_nxt;
      rx_r   <= rx_nxt;
      tix_r  <= tix_nxt;
      more_r <= more_nxt;
      lvl_r  <= lvl_nxt;
      oe_r   <= oe_nxt;
      pend_r <= pend_nxt;
      frm_r  <= frm_nxt;
      stl_r  <= stl_nxt;
      rdw_r  <= rdw_nxt;
    end
  end

  assign fr_if.src_valid = pend_r;
  assign fr_if.src_data  = frm_r;
  assign sda_out         = lvl_r;
  assign sda_oe          = oe_r;

  // ----------------------------------------------------------------
  // core side: command decode and status word on core_clk
  // ----------------------------------------------------------------
  logic                 srq_s1_r, srq_s2_r, sfl_s1_r, sfl_s2_r;
  shsc_pkg::shsc_core_e cst_r, cst_nxt;
  logic [15:0]          cnt_r, cnt_nxt;
  logic                 heat_r, heat_nxt, alrt_r, alrt_nxt;
  logic                 hum_r, hum_nxt, tmp_r, tmp_nxt;
  logic                 rstd_r, rstd_nxt, cmdf_r, cmdf_nxt;
  logic                 wrf_r, wrf_nxt;
  logic [15:0]          stat_r, stat_nxt, sent_r, sent_nxt;
  logic [7:0]           wr_crc;
  logic                 rst_evt, fr_v;
  logic [2:0]           f_nb;
  logic [15:0]          f_cmd;

  assign rst_evt = srq_s2_r | sfl_s2_r;
  assign fr_v    = fr_if.dst_valid;
  assign f_nb    = fr_if.dst_data[42:40];
  assign f_cmd   = fr_if.dst_data[39:24];

  shsc_crc8 u_wr_crc (
    .data (fr_if.dst_data[23:8]),
    .crc  (wr_crc)
  );

  always_comb
  begin
    cst_nxt  = cst_r;
    cnt_nxt  = cnt_r;
    heat_nxt = heat_r;
    alrt_nxt = alrt_r;
    hum_nxt  = hum_r;
    tmp_nxt  = tmp_r;
    rstd_nxt = rstd_r;
    cmdf_nxt = cmdf_r;
    wrf_nxt  = wrf_r;
    if (rst_evt)
    begin
      cst_nxt  = shsc_pkg::cs_busy;
      cnt_nxt  = 16'(RST_CYCLES);
      heat_nxt = 1'b0;
      alrt_nxt = 1'b1;
      hum_nxt  = 1'b0;
      tmp_nxt  = 1'b0;
      rstd_nxt = 1'b1;
      cmdf_nxt = 1'b0;
      wrf_nxt  = 1'b0;
    end
    else
    begin
      case (cst_r)
        // frames landing here are simply dropped
        shsc_pkg::cs_busy:
          if (cnt_r <= 16'h0001)
            cst_nxt = shsc_pkg::cs_run;
          else
            cnt_nxt = cnt_r - 16'h0001;
        shsc_pkg::cs_run:
          if (fr_v && f_nb == `SHSC_NB_CMD)
          begin
            cmdf_nxt = 1'b0;
            case (f_cmd)
              `SHSC_CMD_HEAT_ON:  heat_nxt = 1'b1;
              `SHSC_CMD_HEAT_OFF: heat_nxt = 1'b0;
              `SHSC_CMD_CLR_STAT:
              begin
                alrt_nxt = 1'b0;
                hum_nxt  = 1'b0;
                tmp_nxt  = 1'b0;
                rstd_nxt = 1'b0;
              end
              default: cmdf_nxt = 1'b1;
            endcase
          end
          else if (fr_v && f_nb == `SHSC_NB_WR)
          begin
            wrf_nxt  = (wr_crc != fr_if.dst_data[7:0]);
            cmdf_nxt = 1'b1;
          end
          else if (fr_v && f_nb != 3'h0)
            cmdf_nxt = 1'b1;
        default: cst_nxt = shsc_pkg::cs_busy;
      endcase
    end
    // a new alert beats a clear in the same cycle
    hum_nxt  = hum_nxt | humidity_track_alert;
    tmp_nxt  = tmp_nxt | temp_track_alert;
    alrt_nxt = alrt_nxt | humidity_track_alert | temp_track_alert;
    stat_nxt = {alrt_nxt, 1'b0, heat_nxt, 1'b0, hum_nxt, tmp_nxt,
                5'h00, rstd_nxt, 2'h0, cmdf_nxt, wrf_nxt};
    sent_nxt = (st_if.src_valid && st_if.src_ready) ? stat_r : sent_r;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {srq_s1_r, srq_s2_r, sfl_s1_r, sfl_s2_r} <= 4'h0;
      cst_r  <= shsc_pkg::cs_busy;
      cnt_r  <= 16'(RST_CYCLES);
      heat_r <= 1'b0;
      alrt_r <= 1'b1;
      hum_r  <= 1'b0;
      tmp_r  <= 1'b0;
      rstd_r <= 1'b1;
      cmdf_r <= 1'b0;
      wrf_r  <= 1'b0;
      stat_r <= `SHSC_ST_RESET_VAL;
      sent_r <= `SHSC_ST_RESET_VAL;
    end
    else
    begin
      {srq_s1_r, srq_s2_r} <= {sys_rst_req, srq_s1_r};
      {sfl_s1_r, sfl_s2_r} <= {supply_fail, sfl_s1_r};
      cst_r  <= cst_nxt;
      cnt_r  <= cnt_nxt;
      heat_r <= heat_nxt;
      alrt_r <= alrt_nxt;
      hum_r  <= hum_nxt;
      tmp_r  <= tmp_nxt;
      rstd_r <= rstd_nxt;
      cmdf_r <= cmdf_nxt;
      wrf_r  <= wrf_nxt;
      stat_r <= stat_nxt;
      sent_r <= sent_nxt;
    end
  end

  assign st_if.src_valid = (stat_r != sent_r);
  assign st_if.src_data  = stat_r;
  assign heater_en       = heat_r;
  assign status_word     = stat_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic run_cmd;
  logic wr_bad;
  assign wr_bad  = (wr_crc != fr_if.dst_data[7:0]);
  assign run_cmd = fr_v && !rst_evt && cst_r == shsc_pkg::cs_run
                   && f_nb == `SHSC_NB_CMD;

  property p_heat_on;
    @(posedge core_clk) disable iff (!reset_n)
    run_cmd && f_cmd == `SHSC_CMD_HEAT_ON |=> heater_en ##0 status_word[13];
  endproperty
  a_heat_on: assert property (p_heat_on) else $error("heater not on");

  property p_heat_rst;
    @(posedge core_clk) disable iff (!reset_n)
    rst_evt |=> !heater_en ##0 (!heater_en throughout (!fr_v [*2]));
  endproperty
  a_heat_rst: assert property (p_heat_rst) else $error("heater on");

  property p_heat_bit;
    @(posedge core_clk) disable iff (!reset_n)
    $changed(heater_en) |-> status_word[13] == heater_en;
  endproperty
  a_heat_bit: assert property (p_heat_bit) else $error("bit 13 off");

  property p_alert;
    @(posedge core_clk) disable iff (!reset_n)
    humidity_track_alert |=> status_word[15] && status_word[11];
  endproperty
  a_alert: assert property (p_alert) else $error("alert lost");

  property p_rstd;
    @(posedge core_clk) disable iff (!reset_n)
    rst_evt |=> status_word[4] ##1 status_word[4];
  endproperty
  a_rstd: assert property (p_rstd) else $error("reset flag lost");

  property p_cmd_bad;
    @(posedge core_clk) disable iff (!reset_n)
    run_cmd && f_cmd != `SHSC_CMD_HEAT_ON && f_cmd != `SHSC_CMD_HEAT_OFF
    && f_cmd != `SHSC_CMD_CLR_STAT |=> status_word[1];
  endproperty
  a_cmd_bad: assert property (p_cmd_bad) else $error("bad cmd unflagged");

  property p_wr_crc;
    @(posedge core_clk) disable iff (!reset_n)
    fr_v && !rst_evt && cst_r == shsc_pkg::cs_run && f_nb == `SHSC_NB_WR
    |=> status_word[0] == $past(wr_bad);
  endproperty
  a_wr_crc: assert property (p_wr_crc) else $error("crc flag wrong");

  property p_clear;
    @(posedge core_clk) disable iff (!reset_n)
    run_cmd && f_cmd == `SHSC_CMD_CLR_STAT && !humidity_track_alert
    && !temp_track_alert |=> status_word[15:10] == {2'h0, heater_en, 3'h0}
    && !status_word[4];
  endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared");

  property p_busy;
    @(posedge core_clk) disable iff (!reset_n)
    cst_r == shsc_pkg::cs_busy && !rst_evt |=> $stable(heater_en)
    && $stable(status_word[1]);
  endproperty
  a_busy: assert property (p_busy) else $error("cmd run in reset");

  property p_rsvd;
    @(posedge core_clk) disable iff (!reset_n)
    !status_word[14] && !status_word[12] && status_word[9:2] == 8'h04
    || !status_word[14] && !status_word[12] && status_word[9:2] == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved set");

  c_heat: cover property (@(posedge core_clk) $rose(heater_en));
  c_clr:  cover property (@(posedge core_clk) $fell(status_word[4]));
  c_crcf: cover property (@(posedge core_clk) $rose(status_word[0]));
  c_read: cover property (@(posedge link_clk) lst_r == shsc_pkg::lk_mack);
endmodule

`default_nettype wire

// ==== verilog/shsc_xfer.sv ====
// toggle handshake moving one word between clock domains
// assumes src holds nothing once src_ready has taken its word
`timescale 1ns/10ps
`default_nettype none

module shsc_xfer #(parameter int WIDTH = 8) (
  input  wire logic  src_clk,
  input  wire logic  dst_clk,
  input  wire logic  reset_n,
  shsc_xfer_if.link  x
);
  logic             req_r;
  logic             req_nxt;
  logic [WIDTH-1:0] hold_r;
  logic [WIDTH-1:0] hold_nxt;
  logic             ack_s1_r;
  logic             ack_s2_r;
  logic             rq_s1_r;
  logic             rq_s2_r;
  logic             rq_s3_r;
  logic             dv_r;
  logic [WIDTH-1:0] dd_r;
  logic [WIDTH-1:0] dd_nxt;

  always_comb
  begin
    req_nxt  = req_r;
    hold_nxt = hold_r;
    if (x.src_valid && x.src_ready)
    begin
      req_nxt  = ~req_r;
      hold_nxt = x.src_data;
    end
    dd_nxt = (rq_s2_r != rq_s3_r) ? hold_r : dd_r;
  end

  // hold_r is stable while the toggle travels, so dst samples it whole
  always_ff @(posedge src_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      req_r    <= 1'b0;
      hold_r   <= '0;
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end
    else
    begin
      req_r    <= req_nxt;
      hold_r   <= hold_nxt;
      ack_s1_r <= rq_s3_r;
      ack_s2_r <= ack_s1_r;
    end
  end

  always_ff @(posedge dst_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rq_s1_r <= 1'b0;
      rq_s2_r <= 1'b0;
      rq_s3_r <= 1'b0;
      dv_r    <= 1'b0;
      dd_r    <= '0;
    end
    else
    begin
      rq_s1_r <= req_r;
      rq_s2_r <= rq_s1_r;
      rq_s3_r <= rq_s2_r;
      dv_r    <= rq_s2_r ^ rq_s3_r;
      dd_r    <= dd_nxt;
    end
  end

  assign x.src_ready = (ack_s2_r == req_r);
  assign x.dst_valid = dv_r;
  assign x.dst_data  = dd_r;
endmodule

`default_nettype wire

// ==== verilog/shsc_xfer_if.sv ====
// word carrier between two clock domains
// assumes one shsc_xfer instance drives its far side
`timescale 1ns/10ps
`default_nettype none

interface shsc_xfer_if #(parameter int WIDTH = 8);
  logic             src_valid;
  logic             src_ready;
  logic [WIDTH-1:0] src_data;
  logic             dst_valid;
  logic [WIDTH-1:0] dst_data;

  modport src  (output src_valid, output src_data, input src_ready);
  modport dst  (input dst_valid, input dst_data);
  modport link (input src_valid, input src_data, output src_ready,
                output dst_valid, output dst_data);
endinterface

`default_nettype wire
